//--- bench/adc_channel_gain_sequencer_tb.sv
/*
 Self-checking bench of the scan-sequence block.
 Assumes the design files and afe_model are compiled first.
*/
`timescale 1ns/1ps
`include "seq_defs.svh"
module adc_channel_gain_sequencer_tb;
    import seq_pkg::*;
    logic          clk, rst_n, fwr, cpulse, strig, burst;
    logic [15:0]   fcode, fdata;
    logic [3:0]    mux_pos, mux_neg;
    logic          diff, ref_float, strobe, fifo_wr, dac1, dac2, exh, oe_n, paused, full;
    logic [2:0]    gain;
    logic [1:0]    range_o;
    dig_word_type  dig;
    tbl_cnt_type   cnt;
    logic          got_st, got_fw, got_d1, got_d2, got_ex;
    int            samples, stored, s0, error_cnt, num_checks, cycles;
    conv_word_type tw [4] = '{16'h1013, 16'h428C, 16'h2457, 16'h01F0};
    dig_word_type  db [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
    conv_word_type pw [3] = '{16'h0013, 16'h0821, 16'h0002};

    adc_channel_gain_sequencer u_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_func_wr(fwr), .i_func_code(fcode),
        .i_func_data(fdata), .i_conv_pulse(cpulse), .i_start_trig(strig),
        .i_burst_mode(burst), .o_mux_pos(mux_pos), .o_mux_neg(mux_neg), .o_diff(diff),
        .o_ref_floating(ref_float), .o_gain(gain), .o_range(range_o),
        .o_sample_strobe(strobe), .o_fifo_write(fifo_wr), .o_dac1_update(dac1),
        .o_dac2_update(dac2), .o_exhausted(exh), .o_dig_out(dig), .o_dig_oe_n(oe_n),
        .o_paused(paused), .o_table_full(full), .o_entry_count(cnt));
    afe_model u_afe (.i_clk(clk), .i_rst_n(rst_n), .i_sample_strobe(strobe),
        .i_fifo_write(fifo_wr), .o_samples(samples), .o_stored(stored));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial cycles = 0;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic fw(input logic [15:0] code, input logic [15:0] data);
        @(negedge clk);
        fwr = 1'b1;
        fcode = code;
        fdata = data;
        @(negedge clk);
        fwr = 1'b0;
    endtask
    // Pulse once, then catch the one-cycle strobes within two cycles
    task automatic conv_chk(input logic st, input conv_word_type w, input logic ex);
        @(negedge clk);
        cpulse = 1'b1;
        @(negedge clk);
        cpulse = 1'b0;
        got_st = 1'b0;
        for (int k = 0; k < 2 && !got_st; k++) begin
            if (strobe === 1'b1) begin
                got_st = 1'b1;
                {got_fw, got_d1, got_d2, got_ex} = {fifo_wr, dac1, dac2, exh};
            end else begin
                @(negedge clk);
            end
        end
        chk(got_st, st);
        if (st) begin
            chk(mux_pos, w[10:9] == `TYPE_DIFF ? {1'b0, w[2:0]} : w[3:0]);
            chk(mux_neg, w[10:9] == `TYPE_DIFF ? {1'b1, w[2:0]} : 4'h0);
            chk({diff, ref_float}, {w[10:9] == `TYPE_DIFF, w[10:9] == `TYPE_FLOAT_SE});
            chk({gain, range_o}, {w[6:4], w[8:7]});
            chk({got_fw, got_d1, got_d2, got_ex}, {!w[14], w[12], w[13], ex});
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_latch();
        fw(`FN_CLEAR_BOARD, 16'h0000);
        fw(`FN_TABLE_CLEAR, 16'h0000);
        fw(`FN_LOAD_LATCH, 16'h0535);
        conv_chk(1'b1, 16'h0535, 1'b0);
        $display("test latch done");
    endtask
    task automatic t_table();
        fw(`FN_LOAD_CONV, tw[0]);
        fw(`FN_LOAD_CONV, tw[1]);
        for (int i = 0; i < 4; i++) fw(`FN_LOAD_DIG, {8'h00, db[i]});
        fw(`FN_LOAD_CONV, tw[2]);
        fw(`FN_LOAD_CONV, tw[3]);
        fw(`FN_DIG_EN, 16'h0001);
        idle(2);
        chk(cnt, 16'h0004);
        chk(oe_n, 1'b1);
        conv_chk(1'b1, 16'h0535, 1'b0);
        fw(`FN_TABLE_EN, 16'h0001);
        idle(2);
        chk(oe_n, 1'b0);
        s0 = stored;
        for (int i = 0; i < 9; i++) begin
            conv_chk(1'b1, tw[i%4], i % 4 == 3);
            chk(dig, db[i%4]);
            chk(oe_n, 1'b0);
        end
        idle(2);
        chk(stored - s0, 16'h0007);
        $display("test table done");
    endtask
    task automatic t_pause();
        fw(`FN_CLEAR_BOARD, 16'h0000);
        idle(1);
        chk({oe_n, cnt}, 16'h0800);
        fw(`FN_TABLE_CLEAR, 16'h0000);
        for (int i = 0; i < 3; i++) fw(`FN_LOAD_CONV, pw[i]);
        fw(`FN_TABLE_EN, 16'h0001);
        fw(`FN_PAUSE_EN, 16'h0001);
        conv_chk(1'b1, pw[0], 1'b0);
        conv_chk(1'b1, pw[1], 1'b0);
        idle(1);
        chk(paused, 1'b1);
        conv_chk(1'b0, pw[2], 1'b0);
        @(negedge clk);
        strig = 1'b1;
        @(negedge clk);
        strig = 1'b0;
        idle(1);
        chk(paused, 1'b0);
        conv_chk(1'b1, pw[2], 1'b1);
        burst = 1'b1;
        conv_chk(1'b1, pw[0], 1'b0);
        conv_chk(1'b1, pw[1], 1'b0);
        idle(1);
        chk(paused, 1'b0);
        conv_chk(1'b1, pw[2], 1'b1);
        burst = 1'b0;
        conv_chk(1'b1, pw[0], 1'b0);
        fw(`FN_TABLE_RESET, 16'h0000);
        idle(1);
        chk(cnt, 16'h0003);
        conv_chk(1'b1, pw[0], 1'b0);
        fw(`FN_TABLE_EN, 16'h0000);
        fw(`FN_TABLE_EN, 16'h0001);
        conv_chk(1'b1, pw[2], 1'b1);
        fw(`FN_TABLE_RESET, 16'h0000);
        conv_chk(1'b1, pw[0], 1'b0);
        $display("test pause done");
    endtask
    task automatic t_full();
        fw(`FN_CLEAR_BOARD, 16'h0000);
        fw(`FN_TABLE_CLEAR, 16'h0000);
        for (int i = 0; i < 1024; i++) fw(`FN_LOAD_CONV, {12'h000, i[3:0]});
        idle(1);
        chk({full, cnt}, {1'b1, 11'h400});
        fw(`FN_LOAD_CONV, 16'h000F);
        fw(`FN_TABLE_EN, 16'h0001);
        idle(1);
        chk(cnt, 16'h0400);
        conv_chk(1'b1, 16'h0000, 1'b0);
        fw(`FN_TABLE_CLEAR, 16'h0000);
        idle(1);
        chk({full, cnt}, 16'h0000);
        conv_chk(1'b0, 16'h0000, 1'b0);
        $display("test full done");
    endtask

    initial begin
        rst_n = 1'b0;
        {fwr, cpulse, strig, burst} = 4'h0;
        fcode = 16'h0000;
        fdata = 16'h0000;
        error_cnt = 0;
        num_checks = 0;
        idle(4);
        rst_n = 1'b1;
        idle(1);
        chk({oe_n, paused, full, cnt}, 16'h2000);
        t_latch();
        t_table();
        t_pause();
        t_full();
        tally_and_finish();
    end
endmodule

//--- bench/afe_model.sv
/*
 Converter front-end stand-in: counts samples taken and results stored.
 Assumes one-cycle strobes on the sequencer clock.
*/
`timescale 1ns/1ps
module afe_model (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_sample_strobe,
    input  wire logic i_fifo_write,
    output int        o_samples,
    output int        o_stored
);
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_samples <= 0;
            o_stored  <= 0;
        end else begin
            if (i_sample_strobe) o_samples <= o_samples + 1;
            if (i_fifo_write) o_stored <= o_stored + 1;
        end
    end
endmodule

//--- rtl/adc_channel_gain_sequencer.sv
/*
 Scan-sequence table and stepping logic for a multiplexed converter front end.
 Assumes function writes are single-cycle strobes and conversion pulses come
 from the trigger logic, which also stops the pulses on a stop trigger.
*/
`timescale 1ns/1ps
`include "seq_defs.svh"
module adc_channel_gain_sequencer (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_func_wr,
    input  wire logic [15:0]          i_func_code,
    input  wire logic [15:0]          i_func_data,
    input  wire logic                 i_conv_pulse,
    input  wire logic                 i_start_trig,
    input  wire logic                 i_burst_mode,
    output logic      [3:0]           o_mux_pos,
    output logic      [3:0]           o_mux_neg,
    output logic                      o_diff,
    output logic                      o_ref_floating,
    output logic      [2:0]           o_gain,
    output logic      [1:0]           o_range,
    output logic                      o_sample_strobe,
    output logic                      o_fifo_write,
    output logic                      o_dac1_update,
    output logic                      o_dac2_update,
    output logic                      o_exhausted,
    output logic      [7:0]           o_dig_out,
    output logic                      o_dig_oe_n,
    output logic                      o_paused,
    output logic                      o_table_full,
    output seq_pkg::tbl_cnt_type      o_entry_count
);
    import seq_pkg::*;

    // ----------------------------------------
    // Function decode
    // ----------------------------------------
    logic fn_clear_board;
    logic fn_clear;
    logic fn_reset;
    logic fn_conv;
    logic fn_dig;
    logic fn_latch;
    logic fn_tbl_en;
    logic fn_dig_en;
    logic fn_pause_en;

    assign fn_clear_board = i_func_wr && (i_func_code == `FN_CLEAR_BOARD);
    assign fn_clear       = fn_clear_board || (i_func_wr && (i_func_code == `FN_TABLE_CLEAR));
    assign fn_reset       = i_func_wr && (i_func_code == `FN_TABLE_RESET);
    assign fn_conv        = i_func_wr && (i_func_code == `FN_LOAD_CONV);
    assign fn_dig         = i_func_wr && (i_func_code == `FN_LOAD_DIG);
    assign fn_latch       = i_func_wr && (i_func_code == `FN_LOAD_LATCH);
    assign fn_tbl_en      = i_func_wr && (i_func_code == `FN_TABLE_EN);
    assign fn_dig_en      = i_func_wr && (i_func_code == `FN_DIG_EN);
    assign fn_pause_en    = i_func_wr && (i_func_code == `FN_PAUSE_EN);

    // ----------------------------------------
    // State
    // ----------------------------------------
    tbl_cnt_type   conv_cnt_r;
    tbl_cnt_type   dig_cnt_r;
    tbl_addr_type  ptr_r;
    tbl_addr_type  ptr_nxt;
    conv_word_type latch_r;
    conv_word_type entry;
    dig_word_type  dig_byte;
    logic          table_en_r;
    logic          dig_en_r;
    logic          pause_en_r;
    logic          paused_r;
    logic          ran_r;
    logic          conv_full;
    logic          dig_full;
    logic          use_table;
    logic          step;
    logic          single;
    logic          conv;
    logic          last;
    logic          reenable;

    seq_mem_if mem_bus ();

    seq_table_mem u_mem (
        .i_clk (i_clk),
        .bus   (mem_bus)
    );

    assign conv_full = (conv_cnt_r == `SEQ_DEPTH);
    assign dig_full  = (dig_cnt_r == `SEQ_DEPTH);
    assign use_table = table_en_r && (conv_cnt_r != '0);
    assign step      = i_conv_pulse && use_table && !paused_r;
    assign single    = i_conv_pulse && !table_en_r;
    assign conv      = step || single;
    assign last      = (tbl_cnt_type'({1'b0, ptr_r} + 11'h001) >= conv_cnt_r);
    assign reenable  = fn_tbl_en && i_func_data[0] && !table_en_r && ran_r;
    assign entry     = use_table ? mem_bus.conv_rdata : latch_r;
    assign dig_byte  = mem_bus.dig_rdata;

    // ----------------------------------------
    // Memory writes
    // ----------------------------------------
    assign mem_bus.conv_we    = fn_conv && !conv_full;
    assign mem_bus.conv_waddr = conv_cnt_r[`SEQ_ADDR_W-1:0];
    assign mem_bus.conv_wdata = i_func_data;
    assign mem_bus.dig_we     = fn_dig && !dig_full;
    assign mem_bus.dig_waddr  = dig_cnt_r[`SEQ_ADDR_W-1:0];
    assign mem_bus.dig_wdata  = i_func_data[7:0];
    assign mem_bus.raddr      = ptr_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conv_cnt_r <= '0;
        end else if (fn_clear) begin
            conv_cnt_r <= '0;
        end else if (mem_bus.conv_we) begin
            conv_cnt_r <= conv_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dig_cnt_r <= '0;
        end else if (fn_clear) begin
            dig_cnt_r <= '0;
        end else if (mem_bus.dig_we) begin
            dig_cnt_r <= dig_cnt_r + 11'h001;
        end
    end

    // ----------------------------------------
    // Configuration
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            table_en_r <= 1'b0;
            dig_en_r   <= 1'b0;
            pause_en_r <= 1'b0;
            latch_r    <= '0;
        end else if (fn_clear_board) begin
            table_en_r <= 1'b0;
            dig_en_r   <= 1'b0;
            pause_en_r <= 1'b0;
            latch_r    <= '0;
        end else begin
            if (fn_tbl_en) begin
                table_en_r <= i_func_data[0];
            end
            if (fn_dig_en) begin
                dig_en_r <= i_func_data[0];
            end
            if (fn_pause_en) begin
                pause_en_r <= i_func_data[0];
            end
            if (fn_latch) begin
                latch_r <= i_func_data;
            end
        end
    end

    // ----------------------------------------
    // Stepping
    // ----------------------------------------
    always_comb begin
        ptr_nxt = ptr_r;
        if (fn_clear || fn_reset) begin
            ptr_nxt = '0;
        end else if (step) begin
            ptr_nxt = last ? '0 : ptr_r + 10'h001;
        end else if (reenable) begin
            ptr_nxt = last ? '0 : ptr_r + 10'h001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ran_r <= 1'b0;
        end else if (fn_clear || fn_reset) begin
            ran_r <= 1'b0;
        end else if (step) begin
            ran_r <= 1'b1;
        end
    end

    // Set wins over the start trigger clearing it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            paused_r <= 1'b0;
        end else if (fn_clear || fn_reset) begin
            paused_r <= 1'b0;
        end else if (step && entry[`BIT_PAUSE] && pause_en_r && !i_burst_mode) begin
            paused_r <= 1'b1;
        end else if (i_start_trig) begin
            paused_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Front-end settings
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mux_pos      <= '0;
            o_mux_neg      <= '0;
            o_diff         <= 1'b0;
            o_ref_floating <= 1'b0;
            o_gain         <= '0;
            o_range        <= '0;
        end else if (conv) begin
            o_gain         <= entry[`GAIN_MSB:`GAIN_LSB];
            o_range        <= entry[`RANGE_MSB:`RANGE_LSB];
            o_ref_floating <= (entry[`TYPE_MSB:`TYPE_LSB] == `TYPE_FLOAT_SE);
            if (entry[`TYPE_MSB:`TYPE_LSB] == `TYPE_DIFF) begin
                o_diff    <= 1'b1;
                o_mux_pos <= {1'b0, entry[`CH_MSB-1:0]};
                o_mux_neg <= {1'b1, entry[`CH_MSB-1:0]};
            end else begin
                o_diff    <= 1'b0;
                o_mux_pos <= entry[`CH_MSB:0];
                o_mux_neg <= '0;
            end
        end
    end

    // ----------------------------------------
    // Strobes
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sample_strobe <= 1'b0;
            o_fifo_write    <= 1'b0;
            o_dac1_update   <= 1'b0;
            o_dac2_update   <= 1'b0;
            o_exhausted     <= 1'b0;
        end else begin
            o_sample_strobe <= conv;
            o_fifo_write    <= conv && !entry[`BIT_SKIP];
            o_dac1_update   <= conv && entry[`BIT_DAC1];
            o_dac2_update   <= conv && entry[`BIT_DAC2];
            o_exhausted     <= step && last;
        end
    end

    // ----------------------------------------
    // Digital port and status
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dig_out  <= '0;
            o_dig_oe_n <= 1'b1;
        end else begin
            o_dig_oe_n <= !(dig_en_r && table_en_r);
            if (step && dig_en_r) begin
                o_dig_out <= dig_byte;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_paused      <= 1'b0;
            o_table_full  <= 1'b0;
            o_entry_count <= '0;
        end else begin
            o_paused      <= paused_r;
            o_table_full  <= conv_full;
            o_entry_count <= conv_cnt_r;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_full_drop;
        @(posedge i_clk) disable iff (!i_rst_n)
        (fn_conv && conv_full) |=> (conv_cnt_r == `SEQ_DEPTH);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("write into full table counted");
    property p_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        fn_clear |=> (conv_cnt_r == '0) && (dig_cnt_r == '0) && (ptr_r == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("table not empty after clear");
    property p_append;
        @(posedge i_clk) disable iff (!i_rst_n)
        (fn_conv && !conv_full) |=> (conv_cnt_r == $past(conv_cnt_r) + 11'h001);
    endproperty
    a_append: assert property (p_append) else $error("entry not appended");
    property p_wrap;
        @(posedge i_clk) disable iff (!i_rst_n)
        (step && last && !fn_clear && !fn_reset) |=> (ptr_r == '0) && o_exhausted;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap after last entry");
    property p_pause_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        (paused_r && table_en_r && !i_start_trig && !fn_tbl_en) |=> !o_sample_strobe;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("conversion while paused");
    property p_burst_nopause;
        @(posedge i_clk) disable iff (!i_rst_n)
        (step && i_burst_mode) |=> !paused_r;
    endproperty
    a_burst_nopause: assert property (p_burst_nopause) else $error("paused in burst");
    property p_skip;
        @(posedge i_clk) disable iff (!i_rst_n)
        (conv && entry[`BIT_SKIP]) |=> (o_sample_strobe && !o_fifo_write);
    endproperty
    a_skip: assert property (p_skip) else $error("skip entry written to FIFO");
    property p_dac;
        @(posedge i_clk) disable iff (!i_rst_n)
        (conv && entry[`BIT_DAC1]) |=> (o_dac1_update && o_sample_strobe);
    endproperty
    a_dac: assert property (p_dac) else $error("missing converter update");
    property p_dig_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        !table_en_r |=> o_dig_oe_n;
    endproperty
    a_dig_off: assert property (p_dig_off) else $error("digital port on without table");
    property p_latch;
        @(posedge i_clk) disable iff (!i_rst_n)
        single |=> (o_gain == $past(latch_r[`GAIN_MSB:`GAIN_LSB]));
    endproperty
    a_latch: assert property (p_latch) else $error("single conversion ignored latch");
    property p_reset_keep;
        @(posedge i_clk) disable iff (!i_rst_n)
        (fn_reset && !fn_clear) |=> (ptr_r == '0) && (conv_cnt_r == $past(conv_cnt_r));
    endproperty
    a_reset_keep: assert property (p_reset_keep) else $error("table reset lost entries");
endmodule

//--- rtl/seq_defs.svh
/*
 Constants of the scan-sequence block: function codes, table size, entry fields.
 Assumes it is included by bare name from the design files.
*/
// Function
// - Table holds 1024 entries of 16 conversion bits plus 8 digital bits.
// - Table-clear function empties the table; software clears before a new load.
// - Conversion writes into a full table are dropped, contents unchanged.
// - Each conversion write lands in the next free position.
// - Channel, gain, range and input type come from entry bits 10..0.
// - Sixteen single-ended or eight differential inputs; grounded or floating reference.
// - Enabled pause bit halts stepping at that entry until the next start trigger.
// - Pause bit has no effect in burst mode or with the single-entry latch.
// - Bits 12 and 13 strobe the matching output converter update at sampling.
// - Bit 14 converts but withholds the FIFO write.
// - Each pulse uses current entry, advances, wraps after the last entry.
// - Digital bytes fill positions in order and align with conversion entries.
// - Enabled digital part drives the entry byte onto the second port.
// - Table is used for conversions only after its enable function.
// - Digital output works only while the table itself is enabled.
// - Digital output enable covers the whole sequence, never per entry.
// - Disable then re-enable mid-sequence skips one entry; reset table afterwards.
// - Single-entry latch, loaded by its own function, laid out like an entry.
// - Board-clear command resets all settings and empties the table; table clear only empties it.
// - Wrapping past the last entry signals table exhaustion for burst end.
// - Conversions without the table sample the single-entry latch settings.
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

`define SEQ_DEPTH        11'h400
`define SEQ_ADDR_W       10
`define SEQ_CNT_W        11

`define FN_LOAD_CONV     16'h0300
`define FN_LOAD_LATCH    16'h0301
`define FN_LOAD_DIG      16'h0302
`define FN_TABLE_EN      16'h0303
`define FN_DIG_EN        16'h0304
`define FN_PAUSE_EN      16'h0305
`define FN_TABLE_RESET   16'h030E
`define FN_TABLE_CLEAR   16'h030F
`define FN_CLEAR_BOARD   16'h0010

`define BIT_PAUSE        11
`define BIT_DAC1         12
`define BIT_DAC2         13
`define BIT_SKIP         14
`define CH_MSB           3
`define GAIN_LSB         4
`define GAIN_MSB         6
`define RANGE_LSB        7
`define RANGE_MSB        8
`define TYPE_LSB         9
`define TYPE_MSB         10
`define TYPE_GROUND_SE   2'h0
`define TYPE_FLOAT_SE    2'h1
`define TYPE_DIFF        2'h2

`endif

//--- rtl/seq_mem_if.sv
/*
 Write and read paths between the sequencer and its entry memory.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface seq_mem_if;
    import seq_pkg::*;
    logic          conv_we;
    tbl_addr_type  conv_waddr;
    conv_word_type conv_wdata;
    logic          dig_we;
    tbl_addr_type  dig_waddr;
    dig_word_type  dig_wdata;
    tbl_addr_type  raddr;
    conv_word_type conv_rdata;
    dig_word_type  dig_rdata;
    modport ctrl (output conv_we, conv_waddr, conv_wdata, dig_we, dig_waddr, dig_wdata,
                  raddr, input conv_rdata, dig_rdata);
    modport mem  (input conv_we, conv_waddr, conv_wdata, dig_we, dig_waddr, dig_wdata,
                  raddr, output conv_rdata, dig_rdata);
endinterface

//--- rtl/seq_pkg.sv
/*
 Types of the scan-sequence block.
 Assumes seq_defs.svh for sizes.
*/
`include "seq_defs.svh"
package seq_pkg;
    typedef logic [15:0]              conv_word_type;
    typedef logic [7:0]               dig_word_type;
    typedef logic [`SEQ_ADDR_W-1:0]   tbl_addr_type;
    typedef logic [`SEQ_CNT_W-1:0]    tbl_cnt_type;
endpackage

//--- rtl/seq_table_mem.sv
/*
 Entry memory: 1024 conversion words and 1024 digital bytes, read asynchronously.
 Assumes the controller never writes beyond the loaded count.
*/
`timescale 1ns/1ps
`include "seq_defs.svh"
module seq_table_mem (
    input  wire logic i_clk,
    seq_mem_if.mem    bus
);
    import seq_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    conv_word_type conv_mem [`SEQ_DEPTH];
    dig_word_type  dig_mem  [`SEQ_DEPTH];

    always_ff @(posedge i_clk) begin
        if (bus.conv_we) begin
            conv_mem[bus.conv_waddr] <= bus.conv_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (bus.dig_we) begin
            dig_mem[bus.dig_waddr] <= bus.dig_wdata;
        end
    end

    assign bus.conv_rdata = conv_mem[bus.raddr];
    assign bus.dig_rdata  = dig_mem[bus.raddr];
endmodule
